// >>> hdl/bmc_port_regs.vh
// Timing constants for the biphase-mark serial MCU port
`ifndef BMC_PORT_REGS_VH
`define BMC_PORT_REGS_VH

// ***************************************************
// Clock and line timing
// ***************************************************
// Bit time 3333 ns and idle gap 6666 ns, counted in 50 ns cycles of the 20 MHz clock
// Sized at the counter width so no compare or load drops bits
`define BMC_UI_CYC 8'h42
`define BMC_HALF_CYC 8'h21
`define BMC_LONG_CYC 8'h31
`define BMC_IDLE_CYC 8'h85
`define BMC_SYNC_LAG 8'h02

// ***************************************************
// Port state codes
// ***************************************************
`define BMC_ST_IDLE 2'h0
`define BMC_ST_RX 2'h1
`define BMC_ST_TX 2'h2
`define BMC_ST_TAIL 2'h3

`endif

// >>> hdl/bmc_rx_decoder.v
// Biphase-mark decoder: recovers bits and line activity from the CC level
`timescale 1ns/1ps
`include "bmc_port_regs.vh"

module bmc_rx_decoder (
  // Clock and reset
  input wire clk_in,
  input wire rst_b_in,
  input wire clear_in,
  // Synchronised line level
  input wire line_in,
  // Decoded stream
  output reg bit_valid_out,
  output reg bit_data_out,
  output reg active_out
);

  localparam [7:0] LONG_CYC = `BMC_LONG_CYC;
  localparam [7:0] IDLE_CYC = `BMC_IDLE_CYC;

  reg line_reg;
  reg [7:0] gap_reg;
  reg half_reg;
  wire edge_seen;

  assign edge_seen = line_in ^ line_reg;

  // Interval measure between transitions; a long gap, or the edge after a short one, closes a bit
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      line_reg <= 1'b0;
      gap_reg <= 8'h00;
      half_reg <= 1'b0;
      bit_valid_out <= 1'b0;
      bit_data_out <= 1'b0;
      active_out <= 1'b0;
    end else if (clear_in) begin
      line_reg <= line_in;
      gap_reg <= 8'h00;
      half_reg <= 1'b0;
      bit_valid_out <= 1'b0;
      bit_data_out <= 1'b0;
      active_out <= 1'b0;
    end else begin
      line_reg <= line_in;
      bit_valid_out <= 1'b0;
      if (edge_seen) begin
        gap_reg <= 8'h00;
        active_out <= 1'b1;
        if (!active_out) begin
          // First edge after silence only marks a start
          half_reg <= 1'b0;
        end else if (half_reg || gap_reg >= LONG_CYC) begin
          // A one has two short gaps; the second edge is the boundary
          bit_valid_out <= 1'b1;
          bit_data_out <= half_reg;
          half_reg <= 1'b0;
        end else begin
          half_reg <= 1'b1;
        end
      end else if (gap_reg >= IDLE_CYC) begin
        // No transition for two bit times: line has gone quiet
        active_out <= 1'b0;
        half_reg <= 1'b0;
      end else begin
        gap_reg <= gap_reg + 8'h01;
      end
    end
  end

endmodule

// >>> hdl/bmc_serial_mcu_port.v
// Serial MCU port of the biphase-mark transceiver (device is clock master)
//
// Operation
// - Decoded CC data out, valid at falling clock
// - Device drives open-drain low frame select
// - Transmit request high sends MCU data
// - Request low: default receive, decode to MCU
// - Device generates open-drain serial clock
// - High reset input resets the port
// - Transmit wins over receive
// - Request drop: trailing edge, release line
// - Receive clock from line; release select when quiet
`timescale 1ns/1ps
`include "bmc_port_regs.vh"

module bmc_serial_mcu_port (
  // Clock and reset
  input wire clk_in,
  input wire rst_b_in,
  input wire reset_in,
  // CC line
  input wire cc_rx_in,
  output reg cc_tx_out,
  output reg cc_tx_oe_out,
  // MCU serial link
  input wire tx_req_in,
  input wire sdi_in,
  output reg sdo_out,
  output reg sclk_out,
  output reg sclk_oe_out,
  output reg frame_select_n_out,
  output reg frame_select_n_oe_out
);

  localparam [7:0] UI_CYC = `BMC_UI_CYC;
  localparam [7:0] HALF_CYC = `BMC_HALF_CYC;
  localparam [7:0] SAMPLE_CYC = `BMC_HALF_CYC + `BMC_SYNC_LAG;

  // ***************************************************
  // Reset release and pin synchronisers
  // ***************************************************
  reg [1:0] rst_sync_reg;
  wire rst_b;
  reg [1:0] hw_rst_sync_reg;
  reg [1:0] req_sync_reg;
  reg [1:0] sdi_sync_reg;
  reg [1:0] cc_sync_reg;
  wire hw_rst;
  wire tx_req;
  wire sdi;
  wire cc_line;

  assign rst_b = rst_sync_reg[1];
  assign hw_rst = hw_rst_sync_reg[1];
  assign tx_req = req_sync_reg[1];
  assign sdi = sdi_sync_reg[1];
  assign cc_line = cc_sync_reg[1];

  // Asynchronous assert, synchronous release
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // Two flops on every pin; first stage read only by the second
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      hw_rst_sync_reg <= 2'h0;
      req_sync_reg <= 2'h0;
      sdi_sync_reg <= 2'h0;
      cc_sync_reg <= 2'h0;
    end else begin
      hw_rst_sync_reg <= {hw_rst_sync_reg[0], reset_in};
      req_sync_reg <= {req_sync_reg[0], tx_req_in};
      sdi_sync_reg <= {sdi_sync_reg[0], sdi_in};
      cc_sync_reg <= {cc_sync_reg[0], cc_rx_in};
    end
  end

  // ***************************************************
  // Receive decoder
  // ***************************************************
  wire rx_bit_valid;
  wire rx_bit_data;
  wire rx_active;
  reg [1:0] state_reg;
  wire dec_clear;

  // Decoder is held while transmitting so our own drive is not echoed
  assign dec_clear = hw_rst | (state_reg == `BMC_ST_TX) | (state_reg == `BMC_ST_TAIL);

  bmc_rx_decoder u_dec (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .clear_in(dec_clear),
    .line_in(cc_line),
    .bit_valid_out(rx_bit_valid),
    .bit_data_out(rx_bit_data),
    .active_out(rx_active)
  );

  // ***************************************************
  // Port sequencer
  // ***************************************************
  reg [7:0] ph_cnt_reg;
  reg rx_clk_run_reg;
  reg tx_bit_reg;
  reg tx_have_reg;
  reg cur_one_reg;
  reg term_reg;

  // Main state machine; open-drain pins pull low while their enable is high
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= `BMC_ST_IDLE;
      ph_cnt_reg <= 8'h00;
      rx_clk_run_reg <= 1'b0;
      tx_bit_reg <= 1'b0;
      tx_have_reg <= 1'b0;
      cur_one_reg <= 1'b0;
      term_reg <= 1'b0;
      cc_tx_out <= 1'b0;
      cc_tx_oe_out <= 1'b0;
      sdo_out <= 1'b0;
      sclk_out <= 1'b0;
      sclk_oe_out <= 1'b0;
      frame_select_n_out <= 1'b0;
      frame_select_n_oe_out <= 1'b0;
    end else if (hw_rst) begin
      // Active-high reset pin returns everything to idle
      state_reg <= `BMC_ST_IDLE;
      ph_cnt_reg <= 8'h00;
      rx_clk_run_reg <= 1'b0;
      tx_have_reg <= 1'b0;
      cur_one_reg <= 1'b0;
      term_reg <= 1'b0;
      cc_tx_out <= 1'b0;
      cc_tx_oe_out <= 1'b0;
      sdo_out <= 1'b0;
      sclk_oe_out <= 1'b0;
      frame_select_n_oe_out <= 1'b0;
    end else begin
      case (state_reg)
        `BMC_ST_IDLE: begin
          // Clock and select released, line not driven
          sclk_oe_out <= 1'b0;
          frame_select_n_oe_out <= 1'b0;
          cc_tx_oe_out <= 1'b0;
          ph_cnt_reg <= 8'h00;
          if (tx_req) begin
            // Transmit checked first so it always wins
            state_reg <= `BMC_ST_TX;
            frame_select_n_oe_out <= 1'b1;
            sclk_oe_out <= 1'b1;
            cc_tx_out <= 1'b0;
            cc_tx_oe_out <= 1'b1;
            tx_have_reg <= 1'b0;
            cur_one_reg <= 1'b0;
          end else if (rx_bit_valid) begin
            // First decoded bit opens a receive frame
            state_reg <= `BMC_ST_RX;
            frame_select_n_oe_out <= 1'b1;
            sdo_out <= rx_bit_data;
            rx_clk_run_reg <= 1'b1;
          end
        end
        `BMC_ST_RX: begin
          if (tx_req) begin
            // Receive frame abandoned in favour of transmit
            state_reg <= `BMC_ST_TX;
            sclk_oe_out <= 1'b1;
            cc_tx_out <= 1'b0;
            cc_tx_oe_out <= 1'b1;
            tx_have_reg <= 1'b0;
            cur_one_reg <= 1'b0;
            rx_clk_run_reg <= 1'b0;
            ph_cnt_reg <= 8'h00;
          end else if (rx_bit_valid) begin
            // Clock rises with new data, falls half a bit later
            sdo_out <= rx_bit_data;
            sclk_oe_out <= 1'b0;
            rx_clk_run_reg <= 1'b1;
            ph_cnt_reg <= 8'h00;
          end else if (rx_clk_run_reg) begin
            if (ph_cnt_reg == HALF_CYC - 8'h01) begin
              sclk_oe_out <= 1'b1;
              rx_clk_run_reg <= 1'b0;
            end else begin
              ph_cnt_reg <= ph_cnt_reg + 8'h01;
            end
          end else if (!rx_active) begin
            // Line quiet and last falling edge given: close frame
            state_reg <= `BMC_ST_IDLE;
            sclk_oe_out <= 1'b0;
            frame_select_n_oe_out <= 1'b0;
          end
        end
        `BMC_ST_TX: begin
          ph_cnt_reg <= ph_cnt_reg + 8'h01;
          if (ph_cnt_reg == HALF_CYC - 8'h01) begin
            sclk_oe_out <= 1'b0;
            // Mid-bit transition encodes a one
            if (cur_one_reg) begin
              cc_tx_out <= ~cc_tx_out;
            end
          end
          // Sample after the synchroniser lag behind our rising edge
          if (ph_cnt_reg == SAMPLE_CYC) begin
            tx_bit_reg <= sdi;
            tx_have_reg <= 1'b1;
          end
          if (ph_cnt_reg == UI_CYC - 8'h01) begin
            ph_cnt_reg <= 8'h00;
            cur_one_reg <= tx_have_reg & tx_bit_reg;
            if (tx_have_reg) begin
              cc_tx_out <= ~cc_tx_out;
            end
            if (!tx_req) begin
              // Stop clocking; finish the bit already started
              state_reg <= `BMC_ST_TAIL;
              sclk_oe_out <= 1'b0;
              term_reg <= 1'b0;
            end else begin
              sclk_oe_out <= 1'b1;
            end
          end
        end
        `BMC_ST_TAIL: begin
          ph_cnt_reg <= ph_cnt_reg + 8'h01;
          if (!term_reg) begin
            if (ph_cnt_reg == HALF_CYC - 8'h01 && cur_one_reg) begin
              cc_tx_out <= ~cc_tx_out;
            end
            if (ph_cnt_reg == UI_CYC - 8'h01) begin
              // Trailing edge, then held for half a bit
              cc_tx_out <= ~cc_tx_out;
              term_reg <= 1'b1;
              ph_cnt_reg <= 8'h00;
            end
          end else if (ph_cnt_reg == HALF_CYC - 8'h01) begin
            // Back to default receive, line handed back
            cc_tx_out <= 1'b0;
            cc_tx_oe_out <= 1'b0;
            frame_select_n_oe_out <= 1'b0;
            term_reg <= 1'b0;
            tx_have_reg <= 1'b0;
            state_reg <= `BMC_ST_IDLE;
          end
        end
        default: begin
          state_reg <= `BMC_ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> dv/bmc_port_checker_assertions.sv
// Pin-level checks on the serial MCU port
`timescale 1ns/1ps
module bmc_port_checker (
  // Clock and resets
  input wire clk_in, rst_b_in, reset_in,
  // CC line and MCU link
  input wire cc_rx_in, cc_tx_out, cc_tx_oe_out, tx_req_in, sdi_in,
  input wire sdo_out, sclk_out, sclk_oe_out, frame_select_n_out, frame_select_n_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_pin_reset_idle: assert property (reset_in [*3] |=> !cc_tx_oe_out && !frame_select_n_oe_out && !sclk_oe_out)
    else $error("pin reset left the port active");
  a_tx_start_state: assert property ($rose(cc_tx_oe_out) |-> sclk_oe_out && frame_select_n_oe_out && !cc_tx_out)
    else $error("transmit start outputs wrong");
  a_tx_needs_req: assert property ($rose(cc_tx_oe_out) |-> $past(tx_req_in, 2))
    else $error("CC driven without a request");
  a_rx_clock_fall: assert property ($rose(frame_select_n_oe_out) && !cc_tx_oe_out |-> !sclk_oe_out ##33 sclk_oe_out)
    else $error("receive clock fall not 33 cycles after select");
  a_rx_data_stable: assert property ($rose(sclk_oe_out) && !cc_tx_oe_out |-> $stable(sdo_out))
    else $error("receive data moved at the clock fall");
  a_tx_clock_low: assert property (($rose(sclk_oe_out) && cc_tx_oe_out) ##1 tx_req_in [*4] |-> ##29 !sclk_oe_out)
    else $error("transmit clock low phase not 33 cycles");
  a_cc_with_select: assert property (cc_tx_oe_out |-> frame_select_n_oe_out)
    else $error("CC driven while select released");
  a_idle_clock: assert property (!frame_select_n_oe_out |-> !sclk_oe_out)
    else $error("clock pulled with no transfer");
  a_tail_release: assert property ($fell(cc_tx_oe_out) |-> !cc_tx_out && !frame_select_n_oe_out && !sclk_oe_out)
    else $error("transmit end did not release lines");
  c_tx_start: cover property ($rose(cc_tx_oe_out));
  c_rx_frame: cover property ($rose(frame_select_n_oe_out) && !cc_tx_oe_out);
  c_tx_end: cover property ($fell(cc_tx_oe_out));
endmodule

bind bmc_serial_mcu_port bmc_port_checker bmc_port_checker_i (.clk_in, .rst_b_in, .reset_in, .cc_rx_in, .cc_tx_out,
  .cc_tx_oe_out, .tx_req_in, .sdi_in, .sdo_out, .sclk_out, .sclk_oe_out, .frame_select_n_out, .frame_select_n_oe_out);

// >>> dv/mcu_slave_model.sv
// Behavioural MCU slave facing the serial port
`timescale 1ns/1ps
module mcu_slave_model (
  // Clock and control from the bench
  input wire clk_in,
  input wire go_in,
  input wire [15:0] word_in,
  // Wire levels seen at the MCU pins
  input wire sclk_w_in, fs_w_in, sdo_in,
  // Drive toward the port and captured data
  output reg tx_req_out = 1'b0,
  output reg sdi_out = 1'b1,
  output reg [31:0] rx_bits_out = 32'h0,
  output reg [5:0] rx_cnt_out = 6'h00
);
  reg sclk_q = 1'b1;
  reg armed = 1'b0;
  reg [4:0] idx = 5'h00;
  // Bit 0 is set up with the request; later bits move just after a fall so they are settled by the rise
  // A fall before the first rise of a frame only opens it and carries no bit
  always @(posedge clk_in) begin
    sclk_q <= sclk_w_in;
    if (go_in && !tx_req_out) begin
      tx_req_out <= 1'b1;
      armed <= 1'b0;
      idx <= 5'h00;
      sdi_out <= word_in[0];
    end else if (tx_req_out && !sclk_q && sclk_w_in) begin
      armed <= 1'b1;
      // Last bit is being sampled: request drops before the bit ends
      if (idx == 5'h0F) tx_req_out <= 1'b0;
    end else if (tx_req_out && armed && sclk_q && !sclk_w_in) begin
      idx <= idx + 5'h01;
      sdi_out <= word_in[idx[3:0] + 4'h1];
    end
    // Receive samples at the falling clock, last bit ends up highest
    if (!tx_req_out && !fs_w_in && sclk_q && !sclk_w_in) begin
      rx_bits_out <= {sdo_in, rx_bits_out[31:1]};
      rx_cnt_out <= rx_cnt_out + 6'h01;
    end
  end
endmodule

// >>> dv/tb.sv
// Self-checking bench for the serial MCU port
`timescale 1ns/1ps
module tb;
  reg clk_in = 1'b0, rst_b_in = 1'b0, reset_in = 1'b0, cc_rx_in = 1'b0, go = 1'b0, cc_prev = 1'b0;
  reg [15:0] word = 16'h0000;
  reg [19:0] rx_word;
  reg [5:0] c0;
  wire cc_tx_out, cc_tx_oe_out, tx_req_in, sdi_in, sdo_out, sclk_out, sclk_oe_out, fs_n, fs_oe;
  wire [31:0] rx_bits;
  wire [5:0] rx_cnt;
  integer seed = 24279, n_errors = 0, checks_done = 0, tog = 0, k;
  always #25 clk_in = ~clk_in;
  bmc_serial_mcu_port bmc_serial_mcu_port_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .reset_in(reset_in),
    .cc_rx_in(cc_rx_in), .cc_tx_out(cc_tx_out), .cc_tx_oe_out(cc_tx_oe_out), .tx_req_in(tx_req_in), .sdi_in(sdi_in),
    .sdo_out(sdo_out), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out), .frame_select_n_out(fs_n),
    .frame_select_n_oe_out(fs_oe));
  // Pull-ups on clock and select: wire is low only while pulled
  mcu_slave_model mcu_slave_model_i (.clk_in(clk_in), .go_in(go), .word_in(word), .sclk_w_in(!sclk_oe_out),
    .fs_w_in(!fs_oe), .sdo_in(sdo_out), .tx_req_out(tx_req_in), .sdi_out(sdi_in), .rx_bits_out(rx_bits),
    .rx_cnt_out(rx_cnt));
  // Count CC transitions only while the port drives the line
  always @(posedge clk_in) begin
    if (cc_tx_oe_out && cc_tx_out !== cc_prev) tog = tog + 1;
    cc_prev <= cc_tx_out;
  end
  task check(input [63:0] seen, input [63:0] exp, input [8*12-1:0] what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_in);
    end
  endtask
  // Boundary edge, mid edge for a one; the opening edge carries no bit
  task send_cc(input [19:0] bits);
    integer i;
    begin
      for (i = 0; i < 20; i = i + 1) begin
        cc_rx_in <= !cc_rx_in;
        cyc(33);
        if (bits[i]) cc_rx_in <= !cc_rx_in;
        cyc(33);
      end
      cc_rx_in <= !cc_rx_in;
    end
  endtask
  // One boundary edge per bit, a mid edge per one, plus the trailing edge
  function integer exp_tog(input [15:0] w);
    integer i;
    begin
      exp_tog = 17;
      for (i = 0; i < 16; i = i + 1) exp_tog = exp_tog + w[i];
    end
  endfunction
  task send_tx(input [15:0] w);
    integer t0, i;
    begin
      word <= w;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      t0 = tog;
      cyc(8);
      check(cc_tx_oe_out, 1'b1, "tx drive");
      for (i = 0; i < 4000 && cc_tx_oe_out === 1'b1; i = i + 1) cyc(1);
      check(tog - t0, exp_tog(w), "tx toggles");
      check({cc_tx_oe_out, fs_oe, sclk_oe_out}, 3'h0, "tx release");
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Hang guard, well beyond the expected run of some 12000 cycles
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial begin
    cyc(3);
    check({cc_tx_oe_out, fs_oe, sclk_oe_out, sdo_out}, 4'h0, "reset idle");
    rst_b_in <= 1'b1;
    cyc(8);
    for (k = 0; k < 3; k = k + 1) begin
      rx_word = (k == 0) ? 20'hFFFFF : $random(seed);
      c0 = rx_cnt;
      fork
        send_cc(rx_word);
        begin
          cyc(400);
          check(fs_oe, 1'b1, "rx select");
        end
      join
      cyc(200);
      check(rx_cnt - c0, 6'h14, "rx count");
      check(rx_bits[31:12], rx_word, "rx data");
      check({fs_oe, sclk_oe_out}, 2'h0, "rx quiet");
    end
    $display("test receive done");
    for (k = 0; k < 3; k = k + 1) send_tx((k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : $random(seed));
    $display("test transmit done");
    fork
      send_cc($random(seed));
      begin
        // Request lands between receive clock edges
        cyc(415);
        send_tx($random(seed));
      end
    join
    cyc(300);
    $display("test priority done");
    word <= $random(seed);
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(300);
    reset_in <= 1'b1;
    cyc(4);
    check({cc_tx_oe_out, fs_oe, sclk_oe_out}, 3'h0, "pin reset");
    reset_in <= 1'b0;
    for (k = 0; k < 4000 && tx_req_in === 1'b1; k = k + 1) cyc(1);
    cyc(200);
    check({cc_tx_oe_out, fs_oe, sclk_oe_out}, 3'h0, "reset resume");
    check({sclk_out, fs_n}, 2'h0, "od levels");
    $display("test pin reset done");
    wrap_up;
  end
endmodule
